// ---- include/ascf_pkg.sv ----
/*
 * Shared constants for the serial control front end of an eight-input
 * successive-approximation converter: control-byte layout, mode codes,
 * bit counts and conversion timing.
 * Assumes a 100 MHz core clock; the host must keep acquisition at least 1.5 us.
 */
package ascf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // control byte layout
    localparam int CTRL_W      = 8;
    localparam int BIT_START   = 7;
    localparam int BIT_SEL_HI  = 6;
    localparam int BIT_SEL_LO  = 4;
    localparam int BIT_POL     = 3;
    localparam int BIT_CFG     = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // bit counts
    localparam logic [3:0] CNT_TRACK   = 4'h5;
    localparam logic [3:0] CNT_HOLD    = 4'h8;
    localparam int         RES_W       = 12;
    localparam int         RESTART_BIT = 5;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_INT_US   = 10;
    localparam int CONV_INT_CYC  = (CONV_INT_US * 1000) / CLK_PERIOD_NS;
    localparam int TACQ_MIN_NS   = 1500;
    localparam int TACQ_MIN_CYC  =
        (TACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W        = 16;

    // {cs_n, sclk, din} value held in the synchroniser during reset
    localparam logic [2:0] SYNC_RST = 3'h4;

    typedef enum logic [1:0] {
        CV_IDLE,
        CV_EXT,
        CV_INT_BUSY,
        CV_INT_READY
    } ascf_conv_e;

endpackage

// ---- core/ascf_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is an independent level; no bus coherence is needed.
 */
`timescale 1ns/1ps
`default_nettype none

module ascf_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    if (WIDTH < 1) begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end else if (i_ce) begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;

endmodule

`default_nettype wire

// ---- core/ascf_mux_decode.sv ----
/*
 * Input multiplexer decode: turns the channel-select field and the
 * input configuration into positive and negative channel numbers.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none

module ascf_mux_decode (
    input  wire logic [2:0] i_sel,
    input  wire logic       i_single_ended,
    output logic      [2:0] o_pos_ch,
    output logic      [2:0] o_neg_ch,
    output logic            o_neg_gnd
);

    // select field is {msb, mid, lsb}; pair index lives in mid and lsb
    wire logic       pick_msb = i_sel[2];
    wire logic [1:0] pair     = i_sel[1:0];

    // msb chooses the odd member of the pair as positive
    assign o_pos_ch  = {pair, pick_msb}; // R07
    assign o_neg_ch  = i_single_ended ? 3'h0 : {pair, ~pick_msb}; // R07
    assign o_neg_gnd = i_single_ended; // R05

endmodule

`default_nettype wire

// ---- core/ascf_frontend.sv ----
/*
 * Serial control front end: parses the control byte from the serial
 * pins, times track and hold, runs the conversion strobe and shifts the
 * result out on falling serial-clock edges.
 * Assumes the analog core presents its result on i_sar_result when the
 * conversion starts (external clock) or ends (internal clock); all pin
 * inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01: shift data in on rising clock, select low
// R02: skip leading zeros; first one starts byte
// R03: byte is start, channel, polarity, config, mode
// R04: polarity bit one unipolar, zero bipolar
// R05: config bit one single-ended, zero differential
// R06: mode 00 full, 01 fast, 10 internal, 11 external
// R07: route positive and negative inputs per configuration
// R08: tracking starts on fall after fifth bit
// R09: hold on fall after eighth bit
// R10: host keeps acquisition at least 1.5 us
// R11: host sends control byte before every conversion
// R12: external mode strobe one period before msb
// R13: strobe and data change on falling edges
// R14: all-ones input repeats fifteen-clock conversions
// R15: host uses clock polarity and phase zero
// R16: host uses three byte transfers per conversion
// R17: conversion begins on fall after eighth bit
// R18: internal mode strobe low while converting
// R19: data output released while select high
// R20: idle after reset until a start bit
// R21: capture fields at eighth bit for conversion
module ascf_frontend #(
    parameter int CONV_CYC = ascf_pkg::CONV_INT_CYC,
    parameter int RES_W    = ascf_pkg::RES_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_cs_n,
    input  wire logic             i_sclk,
    input  wire logic             i_din,
    input  wire logic [RES_W-1:0] i_sar_result,
    output logic                  o_dout,
    output logic                  o_dout_oe,
    output logic                  o_strobe,
    output logic                  o_strobe_oe,
    output logic                  o_track,
    output logic                  o_conv_start,
    output logic      [7:0]       o_ctrl_byte,
    output logic      [2:0]       o_pos_ch,
    output logic      [2:0]       o_neg_ch,
    output logic                  o_neg_gnd,
    output logic                  o_unipolar,
    output logic                  o_full_pd,
    output logic                  o_fast_pd
);

    localparam logic [3:0] OUT_LAST = 4'(RES_W);
    localparam logic [3:0] OUT_B5   = 4'(RES_W - ascf_pkg::RESTART_BIT);
    localparam logic [ascf_pkg::BUSY_W-1:0] BUSY_LOAD =
        ascf_pkg::BUSY_W'(CONV_CYC - 1);

    if (RES_W < 6 || RES_W > 15) begin : g_bad_res
        $error("result width must lie between 6 and 15");
    end
    if (CONV_CYC < 1 || CONV_CYC > 65535) begin : g_bad_conv
        $error("internal conversion count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [2:0] pins_s;
    logic       sclk_d;

    ascf_sync #(
        .WIDTH   (3),
        .RST_VAL (ascf_pkg::SYNC_RST)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_async ({i_cs_n, i_sclk, i_din}),
        .o_sync  (pins_s)
    );

    wire logic cs_n_s    = pins_s[2];
    wire logic sclk_s    = pins_s[1];
    wire logic din_s     = pins_s[0];
    wire logic cs_low    = ~cs_n_s;
    wire logic sclk_rise = sclk_s & ~sclk_d;
    wire logic sclk_fall = ~sclk_s & sclk_d;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_d <= 1'b0;
        end else if (i_ce) begin
            sclk_d <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control byte parser

    logic                 [7:0] ctrl_shift;
    logic                 [3:0] bit_cnt;
    ascf_pkg::ascf_conv_e       conv_state;
    logic           [RES_W-1:0] out_sh;
    logic                 [3:0] out_cnt;
    logic [ascf_pkg::BUSY_W-1:0] busy_cnt;
    logic                 [1:0] mode_reg;

    // a new start bit may overlap the tail of an external conversion
    wire logic start_ok   = (conv_state == ascf_pkg::CV_IDLE)
                          | (conv_state == ascf_pkg::CV_INT_READY)
                          | ((conv_state == ascf_pkg::CV_EXT)
                             & (out_cnt >= OUT_B5));
    wire logic busy_bits  = (bit_cnt != 4'h0);
    wire logic take_bit   = cs_low & sclk_rise
                          & (bit_cnt < ascf_pkg::CNT_HOLD)
                          & (busy_bits | (din_s & start_ok));
    wire logic ctrl_done  = cs_low & sclk_fall
                          & (bit_cnt == ascf_pkg::CNT_HOLD);
    wire logic track_go   = cs_low & sclk_fall
                          & (bit_cnt == ascf_pkg::CNT_TRACK);
    wire logic [1:0] new_mode =
        ctrl_shift[ascf_pkg::BIT_MODE_HI:ascf_pkg::BIT_MODE_LO];
    wire logic shift_out  = cs_low & sclk_fall
                          & ((conv_state == ascf_pkg::CV_EXT)
                             | (conv_state == ascf_pkg::CV_INT_READY));
    wire logic bits_left  = (out_cnt < OUT_LAST);
    wire logic busy_done  = (busy_cnt == '0);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bit_cnt    <= 4'h0; // R20
            ctrl_shift <= ascf_pkg::CTRL_RST;
        end else if (i_ce) begin
            if (cs_n_s) begin
                bit_cnt <= 4'h0; // R02
            end else if (ctrl_done) begin
                bit_cnt <= 4'h0;
            end else if (take_bit) begin
                ctrl_shift <= {ctrl_shift[6:0], din_s}; // R01 R02 R03
                bit_cnt    <= bit_cnt + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // track and hold

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_track <= 1'b0;
        end else if (i_ce) begin
            if (ctrl_done) begin
                o_track <= 1'b0; // R09
            end else if (track_go) begin
                o_track <= 1'b1; // R08
            end else if (cs_n_s) begin
                o_track <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field capture and input routing

    logic [2:0] dec_pos;
    logic [2:0] dec_neg;
    logic       dec_gnd;

    ascf_mux_decode u_mux (
        .i_sel          (ctrl_shift[ascf_pkg::BIT_SEL_HI:
                                    ascf_pkg::BIT_SEL_LO]),
        .i_single_ended (ctrl_shift[ascf_pkg::BIT_CFG]),
        .o_pos_ch       (dec_pos),
        .o_neg_ch       (dec_neg),
        .o_neg_gnd      (dec_gnd)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ctrl_byte <= ascf_pkg::CTRL_RST;
            o_pos_ch    <= 3'h0;
            o_neg_ch    <= 3'h0;
            o_neg_gnd   <= 1'b1; // reset routing: channel zero to ground
            o_unipolar  <= 1'b0;
            o_full_pd   <= 1'b0;
            o_fast_pd   <= 1'b0;
        end else if (i_ce && ctrl_done) begin
            o_ctrl_byte <= ctrl_shift; // R21
            o_pos_ch    <= dec_pos; // R07
            o_neg_ch    <= dec_neg; // R07
            o_neg_gnd   <= dec_gnd; // R05
            o_unipolar  <= ctrl_shift[ascf_pkg::BIT_POL]; // R04
            o_full_pd   <= (new_mode == ascf_pkg::MODE_FULL_PD); // R06
            o_fast_pd   <= (new_mode == ascf_pkg::MODE_FAST_PD); // R06
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencing and result shifter

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            conv_state   <= ascf_pkg::CV_IDLE; // R20
            mode_reg     <= ascf_pkg::MODE_FULL_PD;
            o_strobe     <= 1'b0;
            o_dout       <= 1'b0;
            out_sh       <= '0;
            out_cnt      <= 4'h0;
            busy_cnt     <= '0;
            o_conv_start <= 1'b0;
        end else if (i_ce) begin
            o_conv_start <= ctrl_done; // R17
            if (ctrl_done) begin
                mode_reg <= new_mode; // R21
                out_cnt  <= 4'h0;
                o_dout   <= 1'b0;
                case (new_mode) // R06
                    ascf_pkg::MODE_EXT_CLK: begin
                        conv_state <= ascf_pkg::CV_EXT;
                        o_strobe   <= 1'b1; // R12
                        out_sh     <= i_sar_result;
                    end
                    ascf_pkg::MODE_INT_CLK: begin
                        conv_state <= ascf_pkg::CV_INT_BUSY;
                        o_strobe   <= 1'b0; // R18
                        busy_cnt   <= BUSY_LOAD;
                    end
                    default: begin
                        conv_state <= ascf_pkg::CV_IDLE;
                        o_strobe   <= 1'b0;
                    end
                endcase
            end else begin
                case (conv_state)
                    ascf_pkg::CV_EXT: begin
                        if (cs_n_s) begin
                            conv_state <= ascf_pkg::CV_IDLE;
                            o_strobe   <= 1'b0;
                            o_dout     <= 1'b0;
                        end else if (shift_out) begin
                            o_strobe <= 1'b0; // R12 R13
                            if (bits_left) begin
                                o_dout  <= out_sh[RES_W-1]; // R13
                                out_sh  <= {out_sh[RES_W-2:0], 1'b0};
                                out_cnt <= out_cnt + 4'h1;
                            end else begin
                                o_dout     <= 1'b0;
                                conv_state <= ascf_pkg::CV_IDLE; // R14
                            end
                        end
                    end
                    ascf_pkg::CV_INT_BUSY: begin
                        if (busy_done) begin
                            o_strobe   <= 1'b1; // R18
                            out_sh     <= i_sar_result;
                            conv_state <= ascf_pkg::CV_INT_READY;
                        end else begin
                            busy_cnt <= busy_cnt - ascf_pkg::BUSY_W'(1);
                        end
                    end
                    ascf_pkg::CV_INT_READY: begin
                        if (cs_n_s) begin
                            o_dout <= 1'b0;
                        end else if (shift_out && bits_left) begin
                            o_dout  <= out_sh[RES_W-1]; // R13
                            out_sh  <= {out_sh[RES_W-2:0], 1'b0};
                            out_cnt <= out_cnt + 4'h1;
                        end else if (shift_out) begin
                            o_dout <= 1'b0;
                        end
                    end
                    ascf_pkg::CV_IDLE: begin
                        if (cs_n_s) begin
                            o_dout <= 1'b0;
                        end
                    end
                    default: begin
                        conv_state <= ascf_pkg::CV_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output enables

    // internal-clock strobe stays driven with select high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dout_oe   <= 1'b0;
            o_strobe_oe <= 1'b0;
        end else if (i_ce) begin
            o_dout_oe   <= cs_low; // R19
            o_strobe_oe <= cs_low | (mode_reg == ascf_pkg::MODE_INT_CLK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_TAKE_BIT: assert property ( // R01
        i_ce && take_bit |=> bit_cnt == $past(bit_cnt) + 4'h1
    ) else $error("data bit not shifted on rising clock");

    AST_LEAD_ZERO: assert property ( // R02
        i_ce && cs_low && sclk_rise && !din_s && bit_cnt == 4'h0
        |=> bit_cnt == 4'h0
    ) else $error("leading zero counted as data");

    AST_START_MSB: assert property ( // R03
        i_ce && ctrl_done |=> o_ctrl_byte[ascf_pkg::BIT_START]
    ) else $error("captured byte lacks start bit");

    AST_POLARITY: assert property ( // R04
        i_ce && ctrl_done
        |=> o_unipolar == $past(ctrl_shift[ascf_pkg::BIT_POL])
    ) else $error("polarity not taken from bit three");

    AST_POWER_MODE: assert property ( // R06
        i_ce && ctrl_done && new_mode == ascf_pkg::MODE_FULL_PD
        |=> o_full_pd && !o_fast_pd && !o_strobe
    ) else $error("full power-down decode wrong");

    AST_ROUTE: assert property ( // R07
        !o_neg_gnd |-> o_pos_ch[2:1] == o_neg_ch[2:1]
                       && o_pos_ch[0] != o_neg_ch[0]
    ) else $error("differential inputs not an adjacent pair");

    AST_TRACK: assert property ( // R08
        i_ce && track_go |=> o_track
    ) else $error("tracking not started after fifth bit");

    AST_HOLD: assert property ( // R09
        i_ce && ctrl_done |=> !o_track && o_conv_start
    ) else $error("hold or conversion start missing");

    AST_EXT_STROBE: assert property ( // R12
        i_ce && shift_out && o_strobe && conv_state == ascf_pkg::CV_EXT
        |=> !o_strobe && o_dout == $past(out_sh[RES_W-1])
    ) else $error("strobe not followed by result msb");

    AST_FALL_EDGE: assert property ( // R13
        $changed(o_dout) && o_dout_oe && $past(o_dout_oe)
        |-> $past(sclk_fall)
    ) else $error("data output moved off a falling edge");

    AST_INT_STROBE: assert property ( // R18
        $rose(o_strobe) && mode_reg == ascf_pkg::MODE_INT_CLK
        |-> $past(conv_state) == ascf_pkg::CV_INT_BUSY
    ) else $error("internal strobe rose before conversion end");

    AST_RELEASE: assert property ( // R19
        i_ce && cs_n_s |=> !o_dout_oe
    ) else $error("data output driven with select high");

    COV_EXT_DONE: cover property (
        conv_state == ascf_pkg::CV_EXT && shift_out && !bits_left
    );
    COV_INT_DONE: cover property (
        conv_state == ascf_pkg::CV_INT_BUSY && busy_done && i_ce
    );
    COV_OVERLAP: cover property (
        take_bit && conv_state == ascf_pkg::CV_EXT
    );

endmodule

`default_nettype wire

// ---- dv/ascf_host_model.sv ----
/* Serial host model: drives select, clock and data in clock mode 0.
   Assumes a 100 MHz bench clock; pins change 1 ns after its edge. */
`timescale 1ns/1ps
`default_nettype none

module ascf_host_model (
    input  wire logic i_clk,
    input  wire logic i_dout,
    input  wire logic i_strobe,
    input  wire logic i_track,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_din
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // half period, stretched while the sample is being acquired
    task automatic half();
        repeat (4) @(posedge i_clk);
        #1;
        if (i_track === 1'b1) begin
            repeat (36) @(posedge i_clk);
            #1;
        end
    endtask

    task automatic select(input logic on);
        half();
        o_cs_n = ~on;
        if (!on) begin
            o_din = ~o_din; // released: inverse of last
        end
        half();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // n bits msb first; data out and strobe captured at each rise
    task automatic shift(input int n, input logic [31:0] tx,
                         output logic [31:0] rx, st, tk);
        rx = '0;
        st = '0;
        tk = '0;
        for (int i = n - 1; i >= 0; i--) begin
            o_din = tx[i];
            half();
            o_sclk = 1'b1;
            rx = {rx[30:0], i_dout};
            st = {st[30:0], i_strobe};
            tk = {tk[30:0], i_track};
            half();
            o_sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/ascf_frontend_tb_top.sv ----
/* Testbench of the serial control front end with a serial host model.
   Assumes the package and design files are compiled before it. */
`timescale 1ns/1ps
`default_nettype none

module ascf_frontend_tb_top;
    localparam int CONV = 20;
    logic        i_clk;
    logic        i_rst;
    logic [11:0] sar;
    logic        cs_n, sclk, din, dout, dout_oe, strobe, track, conv_start;
    logic [7:0]  ctrl_byte;
    logic [2:0]  pos_ch, neg_ch;
    logic        neg_gnd, unipolar, full_pd, fast_pd;
    int          err_count;
    int          check_count;
    int          conv_n = 0;
    integer      seed;
    logic        ce;
    logic        strobe_oe;
    // released data line shows the inverse of its last value
    wire logic   dout_line = dout_oe ? dout : ~dout;

    ascf_frontend #(.CONV_CYC(CONV)) ascf_frontend_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_din(din), .i_sar_result(sar), .o_dout(dout),
        .o_dout_oe(dout_oe), .o_strobe(strobe), .o_strobe_oe(strobe_oe),
        .o_track(track), .o_conv_start(conv_start),
        .o_ctrl_byte(ctrl_byte), .o_pos_ch(pos_ch), .o_neg_ch(neg_ch),
        .o_neg_gnd(neg_gnd), .o_unipolar(unipolar), .o_full_pd(full_pd),
        .o_fast_pd(fast_pd)
    );

    ascf_host_model host_i (
        .i_clk(i_clk), .i_dout(dout_line), .i_strobe(strobe),
        .i_track(track),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din)
    );

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (conv_start === 1'b1) begin
            conv_n <= conv_n + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [2:0] exp_pos(input logic [2:0] s);
        return {s[1], s[0], s[2]};
    endfunction

    function automatic logic [2:0] exp_neg(input logic [2:0] s,
                                           input logic se);
        return se ? 3'h0 : {s[1], s[0], ~s[2]};
    endfunction

    task automatic fields(input logic [7:0] c);
        chk("ctrl", c, ctrl_byte);
        chk("pos", exp_pos(c[6:4]), pos_ch);
        chk("neg", exp_neg(c[6:4], c[2]), neg_ch);
        chk("gnd", c[2], neg_gnd);
        chk("uni", c[3], unipolar);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // control byte after random leading zeros, then two result bytes
    task automatic ext_conv(input logic [7:0] c);
        logic [31:0] rx, st, tk;
        logic [11:0] res;
        int          z;
        int          n0;
        res = 12'($random(seed));
        z   = $unsigned($random(seed)) % 8;
        sar = res;
        n0  = conv_n;
        host_i.select(1'b1);
        host_i.shift(24 + z, {8'h00, c, 16'h0000}, rx, st, tk);
        host_i.select(1'b0);
        chk("result", {1'b0, res, 3'h0}, rx[15:0]);
        chk("strobe", 32'h0000_8000, st & 32'hFF_FFFF);
        chk("track", 32'h0007_0000, tk & 32'hFF_FFFF);
        chk("starts", 1, conv_n - n0);
        fields(c);
        repeat (4) @(posedge i_clk);
        #1;
        chk("dout oe", 0, dout_oe);
        chk("strobe oe", 0, strobe_oe);
    endtask

    task automatic int_conv(input logic [7:0] c);
        logic [31:0] rx, st, tk;
        logic [11:0] res;
        int          w;
        res = 12'($random(seed));
        sar = res;
        host_i.select(1'b1);
        host_i.shift(8, {24'h0, c}, rx, st, tk);
        repeat (6) @(posedge i_clk);
        #1;
        chk("busy strobe", 0, strobe);
        w = 0;
        while (strobe !== 1'b1 && w < 4 * CONV) begin
            @(posedge i_clk);
            #1;
            w++;
        end
        chk("conv time", 1, (w >= CONV - 6) && (w <= CONV + 2));
        host_i.shift(16, 32'h0, rx, st, tk);
        host_i.select(1'b0);
        chk("int result", {res, 3'h0}, rx[14:0]);
        chk("int strobe oe", 1, strobe_oe);
        chk("int dout oe", 0, dout_oe);
        fields(c);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  c;
        logic [31:0] rx, st, tk;
        int          n0;
        seed        = 32'h74C49321;
        ce          = 1'b1;
        err_count   = 0;
        check_count = 0;
        i_rst       = 1'b1;
        sar         = 12'h000;
        repeat (3) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        chk("idle track", 0, track);
        // frozen clock enable: pin activity leaves no trace
        ce = 1'b0;
        n0 = conv_n;
        host_i.select(1'b1);
        host_i.shift(8, 32'h0000_00FF, rx, st, tk);
        host_i.select(1'b0);
        ce = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        chk("frozen starts", 0, conv_n - n0);
        chk("frozen ctrl", 0, ctrl_byte);
        for (int k = 0; k < 8; k++) begin
            c = {1'b1, 3'(k), 1'($random(seed)), 1'(k >> 1), 2'h3};
            ext_conv(c);
        end
        for (int m = 0; m < 2; m++) begin
            c = {1'b1, 5'($random(seed)), 1'b0, 1'(m)};
            host_i.select(1'b1);
            host_i.shift(8, {24'h0, c}, rx, st, tk);
            host_i.select(1'b0);
            chk("full pd", m == 0, full_pd);
            chk("fast pd", m == 1, fast_pd);
            fields(c);
        end
        n0 = conv_n;
        host_i.select(1'b1);
        host_i.shift(30, 32'hFFFF_FFFF, rx, st, tk);
        host_i.select(1'b0);
        chk("repeat starts", 2, conv_n - n0);
        fields(8'hFF);
        n0 = conv_n;
        host_i.shift(12, 32'hFFFF_FFFF, rx, st, tk);
        chk("deselected", 0, conv_n - n0);
        int_conv({1'b1, 5'($random(seed)), 2'h2});
        int_conv({1'b1, 5'($random(seed)), 2'h2});
        tally_and_finish();
    end

    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
